// [design/wdol_pkg.sv]
// Constants, field layout and types for the watchdog with option latch.
// Assumes one clock that also serves as the oscillator clock of the watchdog.
package wdol_pkg;

    // Register addresses on the 16-bit byte address port
    localparam logic [15:0] OPT_ADDR  = 16'h001F;
    localparam logic [15:0] SVC_ADDR  = 16'hFFFF;
    localparam logic [15:0] STAT_ADDR = 16'h0020;

    // Option latch field positions
    localparam int OPT_SLOW_B  = 7;
    localparam int OPT_DSTOP_B = 6;
    localparam int OPT_DRST_B  = 5;
    localparam int OPT_DPWR_B  = 4;
    localparam int OPT_RATE_B  = 3;
    localparam int OPT_SREC_B  = 2;
    localparam int OPT_STOP_B  = 1;
    localparam int OPT_WDIS_B  = 0;

    // Option latch reset value; stop-detector and rate bits must be 0
    localparam logic [7:0] OPT_RST = 8'h30;

    // Status register field positions
    localparam int STAT_WDC_B  = 0;
    localparam int STAT_LOCK_B = 1;
    localparam int STAT_STOP_B = 2;

    // Watchdog structure and timing counts in oscillator clocks
    localparam int PRE_W       = 12;
    localparam int CNT_W       = 6;
    localparam int SVC_LOW     = 4;
    localparam int TAP_FAST    = 6;
    localparam int TAP_SLOW    = 11;
    localparam int RST_PULSE   = 32;
    localparam int REC_SHORT   = 32;
    localparam int REC_LONG    = 4096;
    localparam int POR_DELAY   = 4096;
    localparam int TMR_W       = 13;

    // Option latch contents
    typedef struct packed {
        logic slow_crystal_sel;
        logic detector_in_stop;
        logic detector_reset_en;
        logic detector_power;
        logic watchdog_rate_sel;
        logic short_recovery;
        logic stop_enable;
        logic watchdog_disable;
    } wdol_opt_t;

    // Stop sequencing states
    typedef enum logic [2:0] {
        ST_RUN   = 3'b001,
        ST_STOP  = 3'b010,
        ST_RECOV = 3'b100
    } wdol_state_t;

endpackage : wdol_pkg

// [design/wdol_top.sv]
// Watchdog timer behind a write-once option latch, with stop sequencing.
// Assumes the CPU side drives the register port and event pulses on core_clk;
// pins (reset pin, test levels, detector trip) arrive asynchronously.
//
// The address-and-strobe port is this design's own decision.
`timescale 1ns/100ps
`default_nettype none

module wdol_top (
    input  wire logic              core_clk,
    input  wire logic              resetn,
    input  wire logic [15:0]       reg_addr,
    input  wire logic [7:0]        reg_wdata,
    input  wire logic              reg_wr,
    input  wire logic              reg_rd,
    output logic [7:0]             reg_rdata,
    input  wire logic [7:0]        reset_vec_lo,
    input  wire logic              int_reset,
    input  wire logic              vec_fetch,
    input  wire logic              stop_exec,
    input  wire logic              stop_wake,
    input  wire logic              rst_pin_n,
    input  wire logic              mon_mode,
    input  wire logic              brk_state,
    input  wire logic              rst_pin_tst,
    input  wire logic              irq_pin_tst,
    input  wire logic              detector_trip,
    output wdol_pkg::wdol_opt_t    opt,
    output logic                   detector_run,
    output logic                   detector_rst_req,
    output logic                   stop_illegal,
    output logic                   stop_active,
    output logic                   rst_out_n,
    output logic                   watchdog_cause
);

    // Synchronised pins: first stage feeds only the second
    logic [3:0] pin_s1_q;
    logic [3:0] pin_s2_q;
    logic       rpin_low;
    logic       tst_rst;
    logic       tst_irq;
    logic       trip;

    // Option latch and lock
    wdol_pkg::wdol_opt_t opt_q;
    logic                lock_q;

    // Watchdog counting
    logic [wdol_pkg::PRE_W-1:0] pre_q;
    logic [wdol_pkg::CNT_W-1:0] cnt_q;
    logic                       tick;
    logic                       ovf;
    logic                       wd_off;
    logic [wdol_pkg::PRE_W-1:0] tap_mask;

    // Sequencing
    wdol_pkg::wdol_state_t      st_q;
    logic [wdol_pkg::TMR_W-1:0] rec_q;
    logic [wdol_pkg::TMR_W-1:0] por_q;
    logic                       por_clr;
    logic [5:0]                 pulse_q;
    logic                       wdc_q;
    logic                       ill_q;
    logic [7:0]                 rdata_q;

    // Decoded accesses
    logic opt_wr;
    logic svc_wr;
    logic stat_rd;
    logic stop_go;

    assign opt_wr  = reg_wr && (reg_addr == wdol_pkg::OPT_ADDR);
    assign svc_wr  = reg_wr && (reg_addr == wdol_pkg::SVC_ADDR);
    assign stat_rd = reg_rd && (reg_addr == wdol_pkg::STAT_ADDR);
    assign stop_go = stop_exec && opt_q.stop_enable && (st_q == wdol_pkg::ST_RUN);

    // Two-flop synchronisers for the asynchronous pins
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            pin_s1_q <= 4'h1;
            pin_s2_q <= 4'h1;
        end else begin
            pin_s1_q <= {detector_trip, irq_pin_tst, rst_pin_tst, rst_pin_n};
            pin_s2_q <= pin_s1_q;
        end
    end

    assign rpin_low = !pin_s2_q[0];
    assign tst_rst  = pin_s2_q[1];
    assign tst_irq  = pin_s2_q[2];
    assign trip     = pin_s2_q[3];

    // Write-once latch; any reset reloads defaults and reopens it
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            opt_q  <= wdol_pkg::OPT_RST;
            lock_q <= 1'b0;
        end else if (int_reset) begin
            opt_q  <= wdol_pkg::OPT_RST;
            lock_q <= 1'b0;
        end else if (opt_wr && !lock_q) begin
            opt_q  <= reg_wdata;
            lock_q <= 1'b1;
        end
    end

    // Option outputs toward clock generator and detector
    assign opt              = opt_q;
    assign detector_run     = opt_q.detector_power &&
                              (st_q != wdol_pkg::ST_STOP || opt_q.detector_in_stop);
    assign detector_rst_req = trip && opt_q.detector_power && opt_q.detector_reset_en;

    // Watchdog is off when disabled, or a test level is present in monitor mode, or the reset-pin test level in break
    assign wd_off = opt_q.watchdog_disable ||
                    (mon_mode && (tst_rst || tst_irq)) ||
                    (brk_state && tst_rst);

    // Counter tick tap: prescaler bits up to and including the tap all ones
    assign tap_mask = opt_q.watchdog_rate_sel ?
                      12'h07F : 12'hFFF;
    assign tick = ((pre_q & tap_mask) == tap_mask);

    // Overflow at 2^N - 16: counter full, tap bits from bit 4 up full, low four zero
    assign ovf = !wd_off && (st_q != wdol_pkg::ST_STOP) &&
                 (cnt_q == 6'h3F) &&
                 ((pre_q & tap_mask & 12'hFF0) == (tap_mask & 12'hFF0)) &&
                 (pre_q[3:0] == 4'h0);

    // Power-on delay counter clearing the prescaler once
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            por_q <= '0;
        end else if (por_q != 13'(wdol_pkg::POR_DELAY)) begin
            por_q <= por_q + 13'h0001;
        end
    end

    assign por_clr = (por_q == 13'(wdol_pkg::POR_DELAY - 1));

    // Prescaler: free running on the oscillator clock, held while in stop
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            pre_q <= '0;
        end else if (int_reset || wd_off || ovf) begin
            pre_q <= '0;
        end else if (stop_go || por_clr || vec_fetch) begin
            pre_q <= '0;
        end else if (st_q == wdol_pkg::ST_STOP) begin
            pre_q <= pre_q;
        end else if (svc_wr) begin
            pre_q <= {8'h00, pre_q[3:0] + 4'h1};
        end else begin
            pre_q <= pre_q + 12'h001;
        end
    end

    // Six-bit counter advanced by the prescaler tap
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            cnt_q <= '0;
        end else if (int_reset || wd_off || ovf || svc_wr) begin
            cnt_q <= '0;
        end else if (st_q != wdol_pkg::ST_STOP && tick) begin
            cnt_q <= cnt_q + 6'h01;
        end
    end

    // Reset pin pulse: with the cause flag the only output of the watchdog, no interrupt exists
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            pulse_q <= '0;
        end else if (ovf) begin
            pulse_q <= 6'(wdol_pkg::RST_PULSE);
        end else if (pulse_q != 6'h00) begin
            pulse_q <= pulse_q - 6'h01;
        end
    end

    assign rst_out_n = (pulse_q == 6'h00);

    // Cause flag: overflow set wins over a status read clear
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            wdc_q <= 1'b0;
        end else if (ovf) begin
            wdc_q <= 1'b1;
        end else if (stat_rd) begin
            wdc_q <= 1'b0;
        end
    end

    assign watchdog_cause = wdc_q;

    // Stop sequencing and recovery delay
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            st_q  <= wdol_pkg::ST_RUN;
            rec_q <= '0;
        end else begin
            case (st_q)
                wdol_pkg::ST_RUN: begin
                    if (stop_go) begin
                        st_q <= wdol_pkg::ST_STOP;
                    end
                end
                wdol_pkg::ST_STOP: begin
                    if (rpin_low) begin
                        st_q  <= wdol_pkg::ST_RECOV;
                        rec_q <= 13'(wdol_pkg::REC_LONG - 1);
                    end else if (stop_wake) begin
                        st_q  <= wdol_pkg::ST_RECOV;
                        rec_q <= opt_q.short_recovery ?
                                 13'(wdol_pkg::REC_SHORT - 1) :
                                 13'(wdol_pkg::REC_LONG - 1);
                    end
                end
                wdol_pkg::ST_RECOV: begin
                    if (rec_q == 13'h0000) begin
                        st_q <= wdol_pkg::ST_RUN;
                    end else begin
                        rec_q <= rec_q - 13'h0001;
                    end
                end
                default: begin
                    st_q <= wdol_pkg::ST_RUN;
                end
            endcase
        end
    end

    assign stop_active = (st_q != wdol_pkg::ST_RUN);

    // Stop request with the instruction disabled flags an illegal opcode
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            ill_q <= 1'b0;
        end else begin
            ill_q <= stop_exec && !opt_q.stop_enable;
        end
    end

    assign stop_illegal = ill_q;

    // Read data one cycle after the strobe; unmapped reads give zero
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) begin
            rdata_q <= '0;
        end else if (reg_rd) begin
            case (reg_addr)
                wdol_pkg::OPT_ADDR:  rdata_q <= opt_q;
                wdol_pkg::SVC_ADDR:  rdata_q <= reset_vec_lo;
                wdol_pkg::STAT_ADDR: rdata_q <= {5'h00, stop_active, lock_q, wdc_q};
                default:             rdata_q <= 8'h00;
            endcase
        end else begin
            rdata_q <= 8'h00;
        end
    end

    assign reg_rdata = rdata_q;

endmodule : wdol_top

`default_nettype wire

// [testbench/wdol_chk.sv]
// Concurrent checks on the watchdog with option latch top ports.
// Assumes one clock, asynchronous active-low reset, bound to wdol_top.
`timescale 1ns/100ps
`default_nettype none
module wdol_chk (
    input wire logic                core_clk,
    input wire logic                resetn,
    input wire logic [15:0]         reg_addr,
    input wire logic                reg_wr,
    input wire logic                reg_rd,
    input wire logic [7:0]          reg_rdata,
    input wire logic [7:0]          reset_vec_lo,
    input wire logic                int_reset,
    input wire logic                stop_exec,
    input wire wdol_pkg::wdol_opt_t opt,
    input wire logic                detector_rst_req,
    input wire logic                stop_illegal,
    input wire logic                stop_active,
    input wire logic                rst_out_n,
    input wire logic                watchdog_cause
);
    logic [5:0] low_q;
    logic       wrote_q;
    default clocking cb @(posedge core_clk); endclocking
    default disable iff (!resetn);
    // Length of the reset pulse seen so far, too long a pulse cannot hide
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) low_q <= 6'h00;
        else low_q <= rst_out_n ? 6'h00 : low_q + 6'h01;
    end
    // Latch written since the last reset of either kind
    always_ff @(posedge core_clk or negedge resetn) begin
        if (!resetn) wrote_q <= 1'b0;
        else if (int_reset) wrote_q <= 1'b0;
        else if (reg_wr && reg_addr == wdol_pkg::OPT_ADDR) wrote_q <= 1'b1;
    end
    sequence s_pulse_start;
        $fell(rst_out_n);
    endsequence
    sequence s_svc_read;
        reg_rd && reg_addr == wdol_pkg::SVC_ADDR;
    endsequence
    chk_svc_read: assert property (s_svc_read |=> reg_rdata == $past(reset_vec_lo))
        else $error("service read data wrong");
    chk_pulse_end: assert property ($rose(rst_out_n) |-> low_q == 6'h20)
        else $error("reset pulse too short");
    chk_pulse_max: assert property (!rst_out_n |-> low_q < 6'h20)
        else $error("reset pulse too long");
    chk_cause_set: assert property (s_pulse_start |-> ##[0:1] watchdog_cause)
        else $error("cause flag not set");
    chk_wdis_quiet: assert property (opt.watchdog_disable && $past(opt.watchdog_disable, 40)
        |-> rst_out_n)
        else $error("disabled watchdog reset");
    chk_stop_bad: assert property (stop_exec && !opt.stop_enable |=> stop_illegal)
        else $error("illegal stop not flagged");
    chk_stop_ok: assert property (stop_exec && opt.stop_enable |=> stop_active && !stop_illegal)
        else $error("enabled stop not taken");
    chk_opt_cause: assert property (!$stable(opt)
        |-> $past(reg_wr && reg_addr == wdol_pkg::OPT_ADDR) || $past(int_reset))
        else $error("option changed without write");
    chk_opt_once: assert property ($past(wrote_q) && !$past(int_reset) |-> $stable(opt))
        else $error("second option write taken");
    chk_det_gate: assert property (detector_rst_req
        |-> opt.detector_power && opt.detector_reset_en)
        else $error("detector reset not gated");
endmodule : wdol_chk
bind wdol_top wdol_chk wdol_chk_i (.core_clk, .resetn, .reg_addr, .reg_wr, .reg_rd, .reg_rdata,
    .reset_vec_lo, .int_reset, .stop_exec, .opt, .detector_rst_req, .stop_illegal,
    .stop_active, .rst_out_n, .watchdog_cause);
`default_nettype wire

// [testbench/watchdog_with_option_latch_test.sv]
// Self-checking bench for the watchdog with option latch.
// Assumes the register port answers one cycle after the read strobe.
`timescale 1ns/100ps
`default_nettype none
module watchdog_with_option_latch_test;
    logic core_clk = 0, resetn = 0, reg_wr = 0, reg_rd = 0, int_reset = 0, vec_fetch = 0;
    logic stop_exec = 0, stop_wake = 0, rst_pin_n = 1, mon_mode = 0, brk_state = 0;
    logic rst_pin_tst = 0, irq_pin_tst = 0, detector_trip = 0;
    logic [15:0] reg_addr = 16'h0000;
    logic [7:0]  reg_wdata = 8'h00, reset_vec_lo = 8'h5a, reg_rdata, d;
    logic        detector_run, detector_rst_req, stop_illegal, stop_active, rst_out_n;
    logic        watchdog_cause, lo;
    wdol_pkg::wdol_opt_t opt;
    int n_fail = 0, n_compared = 0, n;
    logic [7:0]  rows [5] = '{8'h30, 8'h00, 8'h10, 8'h20, 8'hf6};
    logic [11:0] quiet [4] = '{12'h090, 12'h08a, 12'h089, 12'h086};
    wdol_top wdol_top_i (.core_clk, .resetn, .reg_addr, .reg_wdata, .reg_wr, .reg_rd,
        .reg_rdata, .reset_vec_lo, .int_reset, .vec_fetch, .stop_exec, .stop_wake,
        .rst_pin_n, .mon_mode, .brk_state, .rst_pin_tst, .irq_pin_tst, .detector_trip,
        .opt, .detector_run, .detector_rst_req, .stop_illegal, .stop_active, .rst_out_n,
        .watchdog_cause);
    // 250 MHz clock
    initial begin
        forever #2 core_clk = ~core_clk;
    end
    task report_and_stop;
        $display("compared %0d failed %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) $display("ALL CHECKS OK");
        else $display("CHECKS NOT OK");
        $finish;
    endtask : report_and_stop
    task chk(input logic [15:0] s, input logic [15:0] e, input string m);
        n_compared++;
        if (s !== e) begin
            n_fail++;
            $display("BAD %0t %s", $time, m);
        end
    endtask : chk
    task wr(input logic [15:0] a, input logic [7:0] v);
        @(posedge core_clk);
        reg_addr <= a; reg_wdata <= v; reg_wr <= 1'b1;
        @(posedge core_clk);
        reg_wr <= 1'b0;
        #1;
    endtask : wr
    task rd(input logic [15:0] a);
        @(posedge core_clk);
        reg_addr <= a; reg_rd <= 1'b1;
        @(posedge core_clk);
        reg_rd <= 1'b0;
        #1 d = reg_rdata;
    endtask : rd
    // Internal reset pulse, one cycle long
    task ireset;
        @(posedge core_clk);
        int_reset <= 1'b1;
        @(posedge core_clk);
        int_reset <= 1'b0;
        #1;
    endtask : ireset
    // Bounded wait for rst_out_n (sel 0) or stop_active (sel 1) to go low
    task wait_low(input bit sel, input int lim);
        n = 0;
        while (((sel ? stop_active : rst_out_n) === 1'b1) && n < lim) begin
            @(posedge core_clk);
            #1;
            n++;
        end
        if (n >= lim) begin
            n_fail++;
            $display("BAD %0t wait ran out", $time);
            report_and_stop;
        end
    endtask : wait_low
    // Stop entered, then left by wake pulse or by the reset pin
    task do_stop(input bit pin);
        @(posedge core_clk);
        stop_exec <= 1'b1;
        @(posedge core_clk);
        stop_exec <= 1'b0;
        #1 chk(stop_active, 1'b1, "stop not entered");
        repeat (8) @(posedge core_clk);
        if (pin) rst_pin_n <= 1'b0;
        else stop_wake <= 1'b1;
        @(posedge core_clk);
        stop_wake <= 1'b0;
        repeat (7) @(posedge core_clk);
        rst_pin_n <= 1'b1;
        wait_low(1'b1, 6000);
        n = n + 8;
    endtask : do_stop
    initial begin
        repeat (6) @(posedge core_clk);
        resetn <= 1'b1;
        #1 chk(opt, wdol_pkg::OPT_RST, "option reset value");
        chk({rst_out_n, stop_active, watchdog_cause}, 3'b100, "outputs after reset");
        rd(wdol_pkg::SVC_ADDR);
        chk(d, 8'h5a, "service read");
        rd(16'h1234);
        chk(d, 8'h00, "unmapped read");
        $display("reset test done");
        detector_trip <= 1'b1;
        // Each row: fresh latch, one write taken, the next ignored
        foreach (rows[i]) begin
            ireset;
            chk(opt, wdol_pkg::OPT_RST, "latch not reloaded");
            wr(wdol_pkg::OPT_ADDR, rows[i]);
            wr(wdol_pkg::OPT_ADDR, ~rows[i]);
            chk(opt, rows[i], "latch value");
            chk(detector_run, rows[i][4], "detector power");
            chk(detector_rst_req, rows[i][4] & rows[i][5], "detector reset");
        end
        detector_trip <= 1'b0;
        $display("latch rows done");
        // Short period with one service in the middle of it
        ireset;
        wr(wdol_pkg::OPT_ADDR, 8'h0a);
        repeat (5000) @(posedge core_clk);
        wr(wdol_pkg::SVC_ADDR, 8'h00);
        wait_low(1'b0, 9000);
        chk(n >= 8155 && n <= 8180, 1'b1, "overflow time");
        repeat (40) @(posedge core_clk);
        rd(wdol_pkg::STAT_ADDR);
        chk(d[0], 1'b1, "cause flag");
        rd(wdol_pkg::STAT_ADDR);
        chk(d[0], 1'b0, "cause flag clear");
        // Vector fetch late in the period clears only the prescaler: later overflow
        ireset;
        wr(wdol_pkg::OPT_ADDR, 8'h08);
        repeat (8000) @(posedge core_clk);
        vec_fetch <= 1'b1;
        @(posedge core_clk);
        vec_fetch <= 1'b0;
        #1;
        wait_low(1'b0, 400);
        chk(n >= 225 && n <= 255, 1'b1, "vector fetch clear");
        repeat (40) @(posedge core_clk);
        $display("overflow test done");
        // Disabled or test-level watchdog never resets over a short period
        foreach (quiet[i]) begin
            ireset;
            {mon_mode, brk_state, rst_pin_tst, irq_pin_tst} <= quiet[i][3:0];
            wr(wdol_pkg::OPT_ADDR, quiet[i][11:4]);
            lo = 1'b0;
            repeat (9000) begin
                @(posedge core_clk);
                if (rst_out_n !== 1'b1) lo = 1'b1;
            end
            chk(lo, 1'b0, "quiet watchdog reset");
        end
        {mon_mode, brk_state, rst_pin_tst, irq_pin_tst} <= 4'h0;
        $display("quiet test done");
        ireset;
        wr(wdol_pkg::OPT_ADDR, 8'h00);
        @(posedge core_clk);
        stop_exec <= 1'b1;
        @(posedge core_clk);
        stop_exec <= 1'b0;
        #1 chk({stop_illegal, stop_active}, 2'b10, "illegal stop");
        ireset;
        wr(wdol_pkg::OPT_ADDR, 8'h06);
        do_stop(1'b0);
        chk(n >= 32 && n <= 36, 1'b1, "short recovery");
        do_stop(1'b1);
        chk(n >= 4096 && n <= 4104, 1'b1, "pin recovery");
        $display("stop test done");
        report_and_stop;
    end
endmodule : watchdog_with_option_latch_test
`default_nettype wire
